/* File: dv/sps_mem_model.sv */
module sps_mem_model (
	input wire logic clk,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [logic [15:0]];
	initial mem_rdata = 8'h00;
	// read data stands from just after the edge that raises the strobe up to the next edge, where the
	// engine takes it; outside that cycle it toggles so a sample in the wrong cycle shows
	always @(posedge clk) begin
		if (mem_wr)
			mem[mem_addr] = mem_wdata;
		#1;
		if (mem_rd && mem.exists(mem_addr))
			mem_rdata = mem[mem_addr];
		else
			mem_rdata = ~mem_rdata;
	end
endmodule // sps_mem_model

/* File: dv/test_system_page_mode_stack_regs.sv */
module test_system_page_mode_stack_regs;
	import sps_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, irq_entry = 0, segment_push_enable_bit = 0, call_req = 0;
	logic call_seg = 0, stk_req = 0, stk_pop = 0, stk_user = 0, stk_word = 0, bus_request_pin = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, flags = 0, port_io_mask = 0;
	logic [7:0] mem_rdata, reg_rdata_q, mem_wdata_q, addr_data_float_q;
	logic [15:0] pc = 0, stk_wdata = 0, stk_rdata_q, mem_addr_q, system_stack_location_bit, w;
	logic [5:0] code_segment_register = 0, pg = 0;
	logic [9:0] paged_addr_q;
	logic paged_sel_q, stk_done_q, engine_busy_q, mem_wr_q, mem_rd_q, mem_in_regfile_q;
	logic internal_core_clock_tick_q, bus_request_grant_q, strobe_float_q;
	logic [7:0] q_rd [$];
	logic [9:0] q_pg [$];
	logic [24:0] q_wr [$];
	logic [16:0] q_dn [$];
	logic [16:0] t;
	logic [7:0] d;
	int num_errors = 0, n_compared = 0, seed = 32'h919c, n;

	sps_regs u_dut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .paged_sel_q,
		.paged_addr_q, .irq_entry, .segment_push_enable_bit, .call_req, .call_seg, .pc, .flags,
		.code_segment_register, .stk_req, .stk_pop, .stk_user, .stk_word, .stk_wdata, .stk_rdata_q,
		.stk_done_q, .engine_busy_q, .mem_wr_q, .mem_rd_q, .mem_addr_q, .mem_wdata_q, .mem_in_regfile_q,
		.mem_rdata, .internal_core_clock_tick_q, .bus_request_pin, .bus_request_grant_q, .port_io_mask,
		.addr_data_float_q, .strobe_float_q);
	sps_mem_model u_mem (.clk(clk), .mem_wr(mem_wr_q), .mem_rd(mem_rd_q), .mem_addr(mem_addr_q),
		.mem_wdata(mem_wdata_q), .mem_rdata(mem_rdata));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		check("leftover notes", q_rd.size() + q_pg.size() + q_wr.size() + q_dn.size(), 0);
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// every result is matched against the oldest note of its kind
	always @(posedge clk) begin
		#1;
		if (reg_rd)
			check("read data", reg_rdata_q, q_rd.size() ? q_rd.pop_front() : 'x);
		if (paged_sel_q)
			check("paged address", paged_addr_q, q_pg.size() ? q_pg.pop_front() : 'x);
		if (mem_wr_q)
			check("push byte", {mem_in_regfile_q, mem_addr_q, mem_wdata_q},
				q_wr.size() ? q_wr.pop_front() : 'x);
		if (stk_done_q) begin
			check("done with a note", q_dn.size() > 0, 1);
			t = q_dn.size() ? q_dn.pop_front() : 17'h0;
			if (t[16])
				check("pop data", stk_rdata_q, t[15:0]);
		end
	end

	initial begin
		#(25 * 10000);
		num_errors++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clk);
		#2 reg_wr = 1;
		reg_addr = a;
		reg_wdata = v;
		if (a == PAGE_SEL_ADDR)
			pg = v[7:2];
		@(posedge clk);
		#2 reg_wr = 0;
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		#2 reg_rd = 1;
		reg_addr = a;
		q_rd.push_back(e);
		if (a[7:4] == PAGED_GROUP)
			q_pg.push_back({pg, a[3:0]});
		@(posedge clk);
		#2 reg_rd = 0;
	endtask

	// k is {irq, call, segment, explicit, pop, user, word}
	task automatic stk(logic [6:0] k, logic [15:0] v);
		@(posedge clk);
		#2 {irq_entry, call_req, call_seg, stk_req, stk_pop, stk_user, stk_word} = k;
		stk_wdata = v;
		@(posedge clk);
		#2 {irq_entry, call_req, call_seg, stk_req, stk_pop, stk_user, stk_word} = 0;
		check("busy after take", engine_busy_q, 1);
		repeat (20) begin
			@(posedge clk);
			#1;
			if (stk_done_q)
				break;
		end
		check("sequence done", stk_done_q, 1);
		check("idle at done", engine_busy_q, 0);
	endtask

	task automatic pu(logic rf, logic [7:0] b);
		system_stack_location_bit = system_stack_location_bit - 1;
		q_wr.push_back({rf, system_stack_location_bit, b});
	endtask

	task automatic tick_wait();
		repeat (40) begin
			@(posedge clk);
			#1;
			if (internal_core_clock_tick_q)
				break;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		#2 reset = 0;
		rd(OP_MODE_ADDR, MODE_RESET);
		rd(PAGE_SEL_ADDR, 8'h00);
		rd(8'h10, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			d = i ? 8'($random(seed)) : 8'hff;
			wr(PAGE_SEL_ADDR, d);
			rd(PAGE_SEL_ADDR, {d[7:2], 2'b00});
			rd({PAGED_GROUP, d[3:0]}, 8'h00);
		end
		$display("test paging done");
		for (int i = 0; i < 16; i++) begin
			wr(OP_MODE_ADDR, {2'b11, i[3], i[2:0], 2'b00});
			rd(OP_MODE_ADDR, {2'b11, i[3], i[2:0], 2'b00});
			tick_wait();
			tick_wait();
			n = 0;
			do begin
				@(posedge clk);
				#1 n++;
			end while (!internal_core_clock_tick_q && n < 40);
			check("tick period", n, (i[2:0] + 1) * (i[3] ? 2 : 1));
		end
		$display("test clock prescale done");
		for (int j = 0; j < 4; j++) begin
			port_io_mask = 8'($random(seed));
			bus_request_pin = j[0];
			wr(OP_MODE_ADDR, {6'h00, j[1], j[0]});
			repeat (5) @(posedge clk);
			#1 check("grant", bus_request_grant_q, j[1] & j[0]);
			check("float", {strobe_float_q, addr_data_float_q},
				j[0] ? {1'b1, ~port_io_mask} : 9'h000);
		end
		$display("test bus control done");
		wr(OP_MODE_ADDR, 8'h00);
		wr(SSP_HIGH_ADDR, 8'h01);
		wr(SSP_LOW_ADDR, 8'h00);
		system_stack_location_bit = 16'h0100;
		pc = 16'($random(seed));
		flags = 8'($random(seed));
		code_segment_register = 6'($random(seed));
		segment_push_enable_bit = 1;
		for (int k = 0; k < 4; k++) begin
			pu(0, pc[7:0]);
			pu(0, pc[15:8]);
			if (k > 1)
				pu(0, flags);
			if (k == 1 || k == 2)
				pu(0, {2'b00, code_segment_register});
			q_dn.push_back(0);
			segment_push_enable_bit = (k == 2);
			stk(k > 1 ? 7'b1000000 : {2'b01, k[0], 4'h0}, 0);
		end
		rd(SSP_LOW_ADDR, system_stack_location_bit[7:0]);
		rd(SSP_HIGH_ADDR, system_stack_location_bit[15:8]);
		w = 16'($random(seed));
		pu(0, w[7:0]);
		pu(0, w[15:8]);
		q_dn.push_back(0);
		// pushed data never comes from a stack pointer pair
		stk(7'b0001001, w);
		for (int k = 0; k < 2; k++) begin
			q_dn.push_back({1'b1, w});
			stk(7'b0001101, 0);
			// the popped bytes are still there after rewinding the pointer
			if (k == 0)
				wr(SSP_LOW_ADDR, system_stack_location_bit[7:0]);
		end
		system_stack_location_bit = system_stack_location_bit + 2;
		rd(SSP_LOW_ADDR, system_stack_location_bit[7:0]);
		$display("test external system stack done");
		wr(OP_MODE_ADDR, 8'hc0);
		wr(SSP_LOW_ADDR, 8'hd0);
		system_stack_location_bit = 16'h00d0;
		pu(1, pc[7:0]);
		pu(1, pc[15:8]);
		q_dn.push_back(0);
		stk(7'b0100000, 0);
		wr(USP_HIGH_ADDR, 8'h12);
		wr(USP_LOW_ADDR, 8'h40);
		q_wr.push_back({1'b1, 16'h003f, w[7:0]});
		q_dn.push_back(0);
		stk(7'b0001010, w);
		q_dn.push_back({9'h100, w[7:0]});
		stk(7'b0001110, 0);
		rd(USP_HIGH_ADDR, 8'h12);
		rd(USP_LOW_ADDR, 8'h40);
		$display("test internal stacks done");
		repeat (3) @(posedge clk);
		close_out();
	end
endmodule // test_system_page_mode_stack_regs

/* File: logic/sps_regs.sv */
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - paged group shows one of 64 pages of 16 registers, chosen by page select
// - page select holds page 0..63 in bits 7:2; bits 1:0 read zero
// - interrupt entry never pushes page select; handlers save it themselves
// - operating mode resets to e0: internal stacks, halving on, rest zero
// - mode bit 7 puts system stack in register file when 1, memory when 0
// - mode bit 6 puts user stack in register file when 1, memory when 0
// - mode bit 5 halves the oscillator input when set
// - mode bits 4:2 prescale the core clock by one to eight
// - mode bit 1 enables the bus request pin; clear ignores it
// - mode bit 0 floats address/data lines and strobes; clear does nothing
// - lines configured as general I/O are never floated
// - stack pointers pre-decrement on push and post-increment on pop
// - a pop leaves the stack contents untouched
// - interrupt entry pushes PC and flags, plus code segment if enabled
// - call pushes PC only; segment call pushes PC and code segment
// - internal stacks use only the low pointer byte; high byte is reserved
// - system stack pointer low byte is a read/write register
module sps_regs
	import sps_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	output logic paged_sel_q,
	output logic [9:0] paged_addr_q,
	input wire logic irq_entry,
	input wire logic segment_push_enable_bit,
	input wire logic call_req,
	input wire logic call_seg,
	input wire logic [15:0] pc,
	input wire logic [7:0] flags,
	input wire logic [5:0] code_segment_register,
	input wire logic stk_req,
	input wire logic stk_pop,
	input wire logic stk_user,
	input wire logic stk_word,
	input wire logic [15:0] stk_wdata,
	output logic [15:0] stk_rdata_q,
	output logic stk_done_q,
	output logic engine_busy_q,
	output logic mem_wr_q,
	output logic mem_rd_q,
	output logic [15:0] mem_addr_q,
	output logic [7:0] mem_wdata_q,
	output logic mem_in_regfile_q,
	input wire logic [7:0] mem_rdata,
	output logic internal_core_clock_tick_q,
	input wire logic bus_request_pin,
	output logic bus_request_grant_q,
	input wire logic [7:0] port_io_mask,
	output logic [7:0] addr_data_float_q,
	output logic strobe_float_q
);
	import sps_pkg::*;

	typedef struct packed {
		logic [PAGE_W-1:0] page;
		logic [7:0] mode;
		logic [7:0] rdata;
		logic paged_sel;
		logic [9:0] paged_addr;
		logic [1:0] brq_sync;
		logic bus_grant;
		logic [7:0] ad_float;
		logic strobe_float;
		logic [4:0] div_cnt;
		logic clk_tick;
		sps_eng_state_t st;
		logic [3:0][7:0] queue;
		logic [2:0] left;
		logic user;
		logic mem_wr;
		logic mem_rd;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
		logic mem_regfile;
		logic [15:0] pop_data;
		logic done;
		logic busy;
	} sps_main_state_t;

	sps_main_state_t q;
	sps_main_state_t d;

	sps_stk_if usr_if ();
	sps_stk_if sys_if ();

	logic [15:0] cur_ptr;
	logic cur_int;
	logic [4:0] div_last;

	////////////////////////////////////////////////////////////////////////////////
	sps_stack_ptr u_user_sp (
		.clk(clk),
		.reset(reset),
		.sp(usr_if.owner)
	);

	sps_stack_ptr u_sys_sp (
		.clk(clk),
		.reset(reset),
		.sp(sys_if.owner)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.mem_wr = 1'b0;
		d.mem_rd = 1'b0;
		cur_ptr = q.user ? usr_if.ptr : sys_if.ptr;
		cur_int = q.user ? q.mode[USER_STACK_LOC_BIT] : q.mode[SYS_STACK_LOC_BIT];
		usr_if.wr_hi = 1'b0;
		usr_if.wr_lo = 1'b0;
		sys_if.wr_hi = 1'b0;
		sys_if.wr_lo = 1'b0;
		usr_if.wdata = reg_wdata;
		sys_if.wdata = reg_wdata;
		usr_if.internal = q.mode[USER_STACK_LOC_BIT];
		sys_if.internal = q.mode[SYS_STACK_LOC_BIT];
		usr_if.dec = (q.st == S_PUSH) && q.user;
		sys_if.dec = (q.st == S_PUSH) && !q.user;
		usr_if.inc = (q.st == S_POP) && q.user;
		sys_if.inc = (q.st == S_POP) && !q.user;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				PAGE_SEL_ADDR: d.page = reg_wdata[PAGE_MSB:PAGE_LSB];
				OP_MODE_ADDR: d.mode = reg_wdata;
				USP_HIGH_ADDR: usr_if.wr_hi = 1'b1;
				USP_LOW_ADDR: usr_if.wr_lo = 1'b1;
				SSP_HIGH_ADDR: sys_if.wr_hi = 1'b1;
				SSP_LOW_ADDR: sys_if.wr_lo = 1'b1;
				default: d.page = q.page;
			endcase
		end

		// register reads, answered one cycle later; unmapped numbers read zero
		if (reg_rd) begin
			case (reg_addr)
				PAGE_SEL_ADDR: d.rdata = {q.page, 2'b00};
				OP_MODE_ADDR: d.rdata = q.mode;
				USP_HIGH_ADDR: d.rdata = usr_if.ptr[15:8];
				USP_LOW_ADDR: d.rdata = usr_if.ptr[7:0];
				SSP_HIGH_ADDR: d.rdata = sys_if.ptr[15:8];
				SSP_LOW_ADDR: d.rdata = sys_if.ptr[7:0];
				default: d.rdata = 8'h00;
			endcase
		end

		// group f accesses are steered to the selected page
		d.paged_sel = (reg_rd || reg_wr) && (reg_addr[7:4] == PAGED_GROUP);
		d.paged_addr = {q.page, reg_addr[3:0]};

		// float only lines used as bus; general I/O lines keep driving
		d.ad_float = q.mode[BUS_FLOAT_BIT] ? ~port_io_mask : 8'h00;
		d.strobe_float = q.mode[BUS_FLOAT_BIT];

		// the pin is asynchronous: two flops before the enable gate
		d.brq_sync = {q.brq_sync[0], bus_request_pin};
		d.bus_grant = q.mode[BUS_REQ_EN_BIT] & q.brq_sync[1];

		// core clock tick: (prescale + 1) times 2 when halving
		div_last = 5'((({2'b00, q.mode[PRESCALE_MSB:PRESCALE_LSB]} + 5'h01)
			<< q.mode[OSC_HALVING_BIT]) - 5'h01);
		if (q.div_cnt >= div_last) begin
			d.div_cnt = 5'h00;
			d.clk_tick = 1'b1;
		end else begin
			d.div_cnt = q.div_cnt + 5'h01;
			d.clk_tick = 1'b0;
		end

		// stack engine: one byte per cycle on push, two cycles per byte on pop
		unique case (q.st)
			S_IDLE: begin
				if (irq_entry) begin
					// page select is deliberately not part of the frame
					d.queue = {{2'b00, code_segment_register}, flags, pc[15:8], pc[7:0]};
					d.left = segment_push_enable_bit ? IRQ_BYTES_SEG : IRQ_BYTES;
					d.user = 1'b0;
					d.st = S_PUSH;
				end else if (call_req) begin
					d.queue = {8'h00, {2'b00, code_segment_register}, pc[15:8], pc[7:0]};
					d.left = call_seg ? CALLS_BYTES : CALL_BYTES;
					d.user = 1'b0;
					d.st = S_PUSH;
				end else if (stk_req) begin
					d.user = stk_user;
					d.left = stk_word ? 3'h2 : 3'h1;
					if (stk_pop) begin
						d.pop_data = 16'h0000;
						d.st = S_POP;
					end else begin
						// low byte first so the high byte ends at the lower address
						d.queue = {16'h0000, stk_wdata[15:8], stk_wdata[7:0]};
						d.st = S_PUSH;
					end
				end
			end
			S_PUSH: begin
				d.mem_wr = 1'b1;
				d.mem_regfile = cur_int;
				d.mem_addr = cur_int ? {8'h00, cur_ptr[7:0] - 8'h01} : cur_ptr - 16'h0001;
				d.mem_wdata = q.queue[0];
				d.queue = {8'h00, q.queue[3:1]};
				d.left = q.left - 3'h1;
				if (q.left == 3'h1) begin
					d.st = S_IDLE;
					d.done = 1'b1;
				end
			end
			S_POP: begin
				// read only: the popped location keeps its byte
				d.mem_rd = 1'b1;
				d.mem_regfile = cur_int;
				d.mem_addr = cur_int ? {8'h00, cur_ptr[7:0]} : cur_ptr;
				d.left = q.left - 3'h1;
				d.st = S_POPWAIT;
			end
			S_POPWAIT: begin
				d.pop_data = {q.pop_data[7:0], mem_rdata};
				if (q.left == 3'h0) begin
					d.st = S_IDLE;
					d.done = 1'b1;
				end else begin
					d.st = S_POP;
				end
			end
		endcase
		d.busy = (d.st != S_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
			q.page <= PAGE_RESET;
			q.mode <= MODE_RESET;
			q.st <= S_IDLE;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_q = q.rdata;
	assign paged_sel_q = q.paged_sel;
	assign paged_addr_q = q.paged_addr;
	assign stk_rdata_q = q.pop_data;
	assign stk_done_q = q.done;
	assign engine_busy_q = q.busy;
	assign mem_wr_q = q.mem_wr;
	assign mem_rd_q = q.mem_rd;
	assign mem_addr_q = q.mem_addr;
	assign mem_wdata_q = q.mem_wdata;
	assign mem_in_regfile_q = q.mem_regfile;
	assign internal_core_clock_tick_q = q.clk_tick;
	assign bus_request_grant_q = q.bus_grant;
	assign addr_data_float_q = q.ad_float;
	assign strobe_float_q = q.strobe_float;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_PAGED_ADDR: assert property ((reg_rd || reg_wr) && reg_addr[7:4] == PAGED_GROUP
		|=> paged_sel_q && paged_addr_q == {$past(q.page), $past(reg_addr[3:0])})
		else $error("paged access not steered to selected page");
	AST_PAGE_LOW_ZERO: assert property (reg_rd && reg_addr == PAGE_SEL_ADDR |=> reg_rdata_q[1:0] == 2'b00)
		else $error("page select low bits not zero");
	AST_MODE_RESET: assert property ($past(reset) |-> q.mode == MODE_RESET)
		else $error("mode register reset value wrong");
	AST_PUSH_PREDEC: assert property (q.st == S_PUSH && !q.user && !q.mode[SYS_STACK_LOC_BIT] && !reg_wr
		|=> sys_if.ptr == $past(sys_if.ptr) - 16'h0001 && mem_addr_q == sys_if.ptr)
		else $error("system push did not pre-decrement");
	AST_POP_NO_WRITE: assert property (q.st == S_POP |=> !mem_wr_q ##1 !mem_wr_q)
		else $error("write issued during pop");
	AST_IRQ_SEG_FRAME: assert property (q.st == S_IDLE && irq_entry && segment_push_enable_bit
		|=> ##1 mem_wr_q [*4] ##1 !mem_wr_q)
		else $error("interrupt frame with segment is not four bytes");
	AST_IRQ_FRAME: assert property (q.st == S_IDLE && irq_entry && !segment_push_enable_bit
		|=> ##1 mem_wr_q [*3] ##1 !mem_wr_q)
		else $error("interrupt frame is not three bytes");
	AST_CALL_FRAME: assert property (q.st == S_IDLE && !irq_entry && call_req && !call_seg
		|=> ##1 mem_wr_q [*2] ##1 !mem_wr_q)
		else $error("plain call frame is not two bytes");
	AST_BUS_REQ_OFF: assert property (!q.mode[BUS_REQ_EN_BIT] |=> !bus_request_grant_q)
		else $error("bus request passed while disabled");
	AST_FLOAT_IO: assert property (q.mode[BUS_FLOAT_BIT] |=> addr_data_float_q == ~$past(port_io_mask)
		&& strobe_float_q)
		else $error("float does not spare general I/O lines");
	AST_NO_FLOAT: assert property (!q.mode[BUS_FLOAT_BIT] |=> addr_data_float_q == 8'h00 && !strobe_float_q)
		else $error("lines floated while float bit clear");
	AST_INTERNAL_ADDR: assert property (mem_wr_q && mem_in_regfile_q |-> mem_addr_q[15:8] == 8'h00)
		else $error("internal stack address uses high byte");

	// register map
	AST_PAGE_WRITE: assert property (reg_wr && reg_addr == PAGE_SEL_ADDR
		|=> q.page == $past(reg_wdata[PAGE_MSB:PAGE_LSB]))
		else $error("page select write not stored");
	AST_PAGE_HELD: assert property (!(reg_wr && reg_addr == PAGE_SEL_ADDR)
		|=> q.page == $past(q.page))
		else $error("page select changed without a write");
	AST_MODE_WRITE: assert property (reg_wr && reg_addr == OP_MODE_ADDR
		|=> q.mode == $past(reg_wdata))
		else $error("mode write not stored");
	AST_PAGE_READ: assert property (reg_rd && reg_addr == PAGE_SEL_ADDR
		|=> reg_rdata_q == {$past(q.page), 2'b00})
		else $error("page select read wrong");

	// stack engine
	AST_POP_POSTINC: assert property (q.st == S_POP && !q.user && !q.mode[SYS_STACK_LOC_BIT] && !reg_wr
		|=> sys_if.ptr == $past(sys_if.ptr) + 16'h0001 && mem_addr_q == $past(sys_if.ptr))
		else $error("system pop did not post-increment");
	AST_CALLS_FRAME: assert property (q.st == S_IDLE && !irq_entry && call_req && call_seg
		|=> ##1 mem_wr_q [*3] ##1 !mem_wr_q)
		else $error("segment call frame is not three bytes");
	AST_IRQ_FIRST_BYTE: assert property (q.st == S_IDLE && irq_entry
		|=> ##1 mem_wdata_q == $past(pc[7:0], 2))
		else $error("interrupt frame does not start with program counter");
	AST_CALL_FIRST_BYTE: assert property (q.st == S_IDLE && !irq_entry && call_req
		|=> ##1 mem_wdata_q == $past(pc[7:0], 2))
		else $error("call frame does not start with program counter");
	AST_FRAME_ON_SYSTEM: assert property (q.st == S_IDLE && (irq_entry || call_req) |=> !q.user)
		else $error("automatic frame not on system stack");
	AST_POP_INTERNAL_ADDR: assert property (mem_rd_q && mem_in_regfile_q |-> mem_addr_q[15:8] == 8'h00)
		else $error("internal pop address uses high byte");
	AST_INTERNAL_PUSH_LOW: assert property (q.st == S_PUSH && cur_int
		|=> mem_addr_q[7:0] == $past(cur_ptr[7:0]) - 8'h01)
		else $error("internal push not below low pointer byte");

	// clock and bus control
	AST_GRANT_ON: assert property (q.mode[BUS_REQ_EN_BIT] && q.brq_sync[1] |=> bus_request_grant_q)
		else $error("bus request not passed while enabled");
	AST_TICK_FASTEST: assert property (q.mode[OSC_HALVING_BIT:PRESCALE_LSB] == 4'h0
		|=> internal_core_clock_tick_q)
		else $error("undivided core clock tick missing");
endmodule // sps_regs

/* File: logic/sps_stack_ptr.sv */
module sps_stack_ptr
	import sps_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	sps_stk_if.owner sp
);
	typedef struct packed {
		logic [15:0] ptr;
	} sps_ptr_state_t;

	sps_ptr_state_t q;
	sps_ptr_state_t d;

	always_comb begin
		d = q;
		// software writes win; pushing a pointer onto itself is a software fault anyway
		if (sp.wr_lo || sp.wr_hi) begin
			if (sp.wr_lo) begin
				d.ptr[7:0] = sp.wdata;
			end
			if (sp.wr_hi) begin
				d.ptr[15:8] = sp.wdata;
			end
		end else if (sp.dec) begin
			if (sp.internal) begin
				d.ptr[7:0] = q.ptr[7:0] - 8'h01;
			end else begin
				d.ptr = q.ptr - 16'h0001;
			end
		end else if (sp.inc) begin
			if (sp.internal) begin
				d.ptr[7:0] = q.ptr[7:0] + 8'h01;
			end else begin
				d.ptr = q.ptr + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '{ptr: SP_RESET};
		end else begin
			q <= d;
		end
	end

	assign sp.ptr = q.ptr;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_INTERNAL_HIGH_KEPT: assert property (sp.internal && !sp.wr_hi |=> sp.ptr[15:8] == $past(sp.ptr[15:8]))
		else $error("high pointer byte changed while stack is internal");
endmodule // sps_stack_ptr

/* File: pkg/sps_pkg.sv */
package sps_pkg;
	// register numbers inside the register file
	localparam logic [7:0] PAGE_SEL_ADDR = 8'hea;
	localparam logic [7:0] OP_MODE_ADDR = 8'heb;
	localparam logic [7:0] USP_HIGH_ADDR = 8'hec;
	localparam logic [7:0] USP_LOW_ADDR = 8'hed;
	localparam logic [7:0] SSP_HIGH_ADDR = 8'hee;
	localparam logic [7:0] SSP_LOW_ADDR = 8'hef;
	localparam logic [3:0] PAGED_GROUP = 4'hf;
	// page select layout
	localparam int PAGE_MSB = 7;
	localparam int PAGE_LSB = 2;
	localparam int PAGE_W = 6;
	localparam logic [5:0] PAGE_RESET = 6'h00;
	// operating mode layout
	localparam logic [7:0] MODE_RESET = 8'he0;
	localparam int SYS_STACK_LOC_BIT = 7;
	localparam int USER_STACK_LOC_BIT = 6;
	localparam int OSC_HALVING_BIT = 5;
	localparam int PRESCALE_MSB = 4;
	localparam int PRESCALE_LSB = 2;
	localparam int BUS_REQ_EN_BIT = 1;
	localparam int BUS_FLOAT_BIT = 0;
	localparam logic [15:0] SP_RESET = 16'h0000;
	// bytes queued per automatic push sequence
	localparam logic [2:0] IRQ_BYTES_SEG = 3'h4;
	localparam logic [2:0] IRQ_BYTES = 3'h3;
	localparam logic [2:0] CALLS_BYTES = 3'h3;
	localparam logic [2:0] CALL_BYTES = 3'h2;

	typedef enum logic [1:0] {S_IDLE, S_PUSH, S_POP, S_POPWAIT} sps_eng_state_t;
endpackage

/* File: pkg/sps_stk_if.sv */
interface sps_stk_if;
	logic wr_hi;
	logic wr_lo;
	logic [7:0] wdata;
	logic dec;
	logic inc;
	logic internal;
	logic [15:0] ptr;
	modport owner (input wr_hi, input wr_lo, input wdata, input dec, input inc, input internal, output ptr);
	modport user (output wr_hi, output wr_lo, output wdata, output dec, output inc, output internal, input ptr);
endinterface
